// file: hdl/gtc_pkg.sv
package gtc_pkg;

    localparam int          CNT_W         = 16;
    localparam int          BYTE_W        = 8;
    localparam int          PS_W          = 3;
    localparam int          NUM_GATE_SRC  = 4;
    localparam int          SYNC_STAGES   = 3;
    // Byte positions inside the count
    localparam int          LOW_LSB       = 0;
    localparam int          HIGH_LSB      = 8;
    // Instruction cycle is four system clocks
    localparam logic [1:0]  PHASE_RST     = 2'h0;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;
    localparam logic [15:0] CNT_RST       = 16'h0000;
    localparam logic [15:0] CNT_MAX       = 16'hffff;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    localparam logic [2:0]  PS_RST        = 3'h0;
    localparam logic [2:0]  PS_ONE        = 3'h1;
    localparam logic [15:0] CNT_ONE       = 16'h0001;

    typedef enum logic [1:0] {
        SRC_INSTR   = 2'h0,
        SRC_FULL    = 2'h1,
        SRC_EXT     = 2'h2,
        SRC_EXT_INV = 2'h3
    } gtc_src_t;

    typedef enum logic [2:0] {
        SP_IDLE  = 3'b001,
        SP_ARMED = 3'b010,
        SP_OPEN  = 3'b100
    } gtc_sp_state_t;

    typedef struct packed {
        logic       on;
        logic       gate_qualify_enable;
        logic       gate_polarity;
        logic       gate_toggle_mode;
        logic       gate_single_pulse_mode;
        logic [1:0] prescale_select;
        logic       atomic_wide_access;
        logic       input_unaligned;
        gtc_src_t   clk_src;
        logic [1:0] gate_source_select;
        logic       gate_event_irq_enable;
        logic       overflow_irq_enable;
    } gtc_cfg_t;

    typedef struct packed {
        logic       wr_low;
        logic       wr_high;
        logic       rd_low;
        logic       rd_high;
        logic [7:0] wdata;
    } gtc_bus_t;

    // Prescaler terminal pattern: 1, 2, 4 or 8
    function automatic logic [2:0] ps_mask(input logic [1:0] sel);
        logic [2:0] m;
        m = 3'h0;
        unique case (sel)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            2'h3: m = 3'h7;
        endcase
        return m;
    endfunction

endpackage

// file: hdl/gtc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gtc_sync (
    // Clock and reset
    input  wire logic MCLK_IN,
    input  wire logic RST_IN,
    // Pin and clean level
    input  wire logic D_IN,
    output logic      Q_OUT
);
    import gtc_pkg::*;

    logic [SYNC_STAGES-1:0] stage;

    // Level accepted once second and third stage agree
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            stage <= '0;
            Q_OUT <= 1'b0;
        end else begin
            stage <= {stage[SYNC_STAGES-2:0], D_IN};
            if (stage[1] == stage[2]) begin
                Q_OUT <= stage[2];
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/gtc_gate.sv
`timescale 1ns/1ps
`default_nettype none
module gtc_gate (
    // Clock and reset
    input  wire logic             MCLK_IN,
    input  wire logic             RST_IN,
    // Configuration and sources
    input  wire gtc_pkg::gtc_cfg_t CFG_IN,
    input  wire logic [3:0]       SRC_IN,
    input  wire logic             ARM_SET_IN,
    // Gate control
    output logic                  GATE_CTL_OUT,
    output logic                  ARM_DONE_OUT
);
    import gtc_pkg::*;

    gtc_sp_state_t sp_state;
    gtc_sp_state_t next_sp_state;
    logic          pol_d;
    logic          tff;
    logic          shaped_d;
    wire           sel_src;
    wire           pol;
    wire           pol_rise;
    wire           shaped;
    wire           s_rise;
    wire           s_fall;

    assign sel_src  = SRC_IN[CFG_IN.gate_source_select];
    assign pol      = CFG_IN.gate_polarity ? sel_src : ~sel_src;
    assign pol_rise = pol & ~pol_d;
    assign shaped   = CFG_IN.gate_toggle_mode ? tff : pol;
    assign s_rise   = shaped & ~shaped_d;
    assign s_fall   = ~shaped & shaped_d;

    always_comb begin
        next_sp_state = sp_state;
        if (!CFG_IN.gate_single_pulse_mode) begin
            next_sp_state = SP_IDLE;
        end else begin
            unique case (sp_state)
                SP_IDLE:  if (ARM_SET_IN) next_sp_state = SP_ARMED;
                SP_ARMED: if (s_rise) next_sp_state = SP_OPEN;
                SP_OPEN:  if (s_fall) next_sp_state = SP_IDLE;
                default:  next_sp_state = SP_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            pol_d    <= 1'b0;
            tff      <= 1'b0;
            shaped_d <= 1'b0;
            sp_state <= SP_IDLE;
        end else begin
            pol_d    <= pol;
            tff      <= CFG_IN.gate_toggle_mode & (tff ^ pol_rise);
            shaped_d <= shaped;
            sp_state <= next_sp_state;
        end
    end

    // Window opens on the rising edge itself
    assign GATE_CTL_OUT = CFG_IN.gate_single_pulse_mode
        ? shaped & ((sp_state == SP_OPEN) | ((sp_state == SP_ARMED) & s_rise))
        : shaped;
    assign ARM_DONE_OUT = (sp_state != SP_IDLE);

    property p_tff_clear;
        @(posedge MCLK_IN) disable iff (RST_IN)
        !CFG_IN.gate_toggle_mode |=> !tff;
    endproperty
    a_tff_clear: assert property (p_tff_clear)
        else $error("toggle flip-flop not held clear");

    property p_arm_clear;
        @(posedge MCLK_IN) disable iff (RST_IN)
        !CFG_IN.gate_single_pulse_mode |=> !ARM_DONE_OUT;
    endproperty
    a_arm_clear: assert property (p_arm_clear)
        else $error("arm bit survived single-pulse disable");

    property p_pulse_done;
        @(posedge MCLK_IN) disable iff (RST_IN)
        (sp_state == SP_OPEN) && s_fall && CFG_IN.gate_single_pulse_mode
            |=> (sp_state == SP_IDLE) && !GATE_CTL_OUT;
    endproperty
    a_pulse_done: assert property (p_pulse_done)
        else $error("single pulse did not close on trailing edge");
endmodule
`default_nettype wire

// file: hdl/gtc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Counts only when on; gate-enable qualifies
// - Sixteen-bit up counter; writes load directly
// - Full-rate source adds four per instruction
// - External mode needs falling edge first
// - External source counts rising pin edges; inverted source counts falling pin edges
// - Prescale 1/2/4/8; cleared by count write
// - Unaligned external input keeps counting asleep
// - Mode switch may gain or lose one
// - Each byte read returns a valid byte
// - Atomic-mode low read snapshots high byte to shadow
// - Atomic mode: high to shadow, low loads
// - Atomic high write keeps the prescaler
// - Gate active level set by polarity
// - Gate source selected, polarity applied after
// - Toggle flip-flop; cleared while toggle off
// - Single pulse: armed, opens, closes, self-clears
// - Leaving single-pulse mode clears arm bit
// - Toggle and single pulse combine
// - Gate level status always live
// - Gate level fall sets gate event flag
// - Wrap to zero sets overflow flag
// - Special event clears count; writes win
module gtc_timer (
    // Clock and reset
    input  wire logic              MCLK_IN,
    input  wire logic              RST_IN,
    // Configuration
    input  wire gtc_pkg::gtc_cfg_t CFG_IN,
    // Byte access
    input  wire gtc_pkg::gtc_bus_t BUS_IN,
    output logic [7:0]             RDATA_OUT,
    // Software and system events
    input  wire logic              PULSE_ARM_SET_IN,
    input  wire logic              OVERFLOW_FLAG_CLR_IN,
    input  wire logic              GATE_EVENT_FLAG_CLR_IN,
    input  wire logic              SPECIAL_EVENT_IN,
    input  wire logic              SLEEP_IN,
    // Pins
    input  wire logic              EXTERNAL_COUNT_INPUT_IN,
    input  wire logic [3:0]        GATE_INPUT_IN,
    // Status
    output logic [15:0]            COUNT_VALUE_OUT,
    output logic                   OVERFLOW_FLAG_OUT,
    output logic                   GATE_EVENT_FLAG_OUT,
    output logic                   GATE_LEVEL_STATUS_OUT,
    output logic                   PULSE_ARM_DONE_OUT,
    output logic                   OVERFLOW_IRQ_OUT,
    output logic                   GATE_IRQ_OUT
);
    import gtc_pkg::*;

    logic [15:0] count;
    logic [15:0] next_count;
    logic [7:0]  shadow;
    logic [7:0]  next_shadow;
    logic [7:0]  next_rdata;
    logic [2:0]  ps_cnt;
    logic [2:0]  next_ps_cnt;
    logic [1:0]  phase;
    logic        ext_sel_d;
    logic        need_fall;
    logic        ext_pend;
    logic        gate_lvl;
    logic        ovf_flag;
    logic        gev_flag;
    logic        ext_lvl;
    logic [3:0]  gate_sync;
    logic        gate_ctl;
    logic        arm_done;

    wire         instr_tick;
    wire         ext_is;
    wire         ext_sel;
    wire         ext_rise;
    wire         ext_fall;
    wire         ext_edge;
    wire         ext_tick;
    wire         src_tick;
    wire         run_ok;
    wire         cnt_en;
    wire         ps_tick;
    wire [2:0]   mask;
    wire         inc;
    wire         any_wr;
    wire         cnt_wr;
    wire         ps_clr;
    wire         ovf_set;
    wire         gate_fall;

    gtc_sync u_ext_sync (
        .MCLK_IN (MCLK_IN),
        .RST_IN  (RST_IN),
        .D_IN    (EXTERNAL_COUNT_INPUT_IN),
        .Q_OUT   (ext_lvl)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_GATE_SRC; g++) begin : g_gate_sync
            gtc_sync u_sync (
                .MCLK_IN (MCLK_IN),
                .RST_IN  (RST_IN),
                .D_IN    (GATE_INPUT_IN[g]),
                .Q_OUT   (gate_sync[g])
            );
        end
    endgenerate

    gtc_gate u_gate (
        .MCLK_IN      (MCLK_IN),
        .RST_IN       (RST_IN),
        .CFG_IN       (CFG_IN),
        .SRC_IN       (gate_sync),
        .ARM_SET_IN   (PULSE_ARM_SET_IN),
        .GATE_CTL_OUT (gate_ctl),
        .ARM_DONE_OUT (arm_done)
    );

    // Count source selection
    assign instr_tick = (phase == PHASE_LAST);
    assign ext_is     = (CFG_IN.clk_src == SRC_EXT) |
                        (CFG_IN.clk_src == SRC_EXT_INV);
    assign ext_sel    = (CFG_IN.clk_src == SRC_EXT_INV) ? ~ext_lvl : ext_lvl;
    assign ext_rise   = ext_sel & ~ext_sel_d;
    assign ext_fall   = ~ext_sel & ext_sel_d;
    assign ext_edge   = ext_is & ext_rise & ~need_fall;
    // Aligned mode lands edges on the instruction boundary
    assign ext_tick   = CFG_IN.input_unaligned ? ext_edge
                      : instr_tick & (ext_pend | ext_edge);
    assign src_tick   = (CFG_IN.clk_src == SRC_INSTR) ? instr_tick
                      : (CFG_IN.clk_src == SRC_FULL)  ? 1'b1
                      : ext_tick;
    assign run_ok     = ~SLEEP_IN | (ext_is & CFG_IN.input_unaligned);
    assign cnt_en     = CFG_IN.on &
                        (~CFG_IN.gate_qualify_enable | gate_ctl);
    assign ps_tick    = src_tick & cnt_en & run_ok;
    assign mask       = ps_mask(CFG_IN.prescale_select);
    assign inc        = ps_tick & ((ps_cnt & mask) == mask);

    // Register access decode
    assign any_wr  = BUS_IN.wr_low | BUS_IN.wr_high;
    assign cnt_wr  = BUS_IN.wr_low |
                     (BUS_IN.wr_high & ~CFG_IN.atomic_wide_access);
    assign ps_clr  = cnt_wr;
    assign ovf_set = inc & (count == CNT_MAX) & ~cnt_wr &
                     ~SPECIAL_EVENT_IN;
    assign gate_fall = gate_lvl & ~gate_ctl;

    always_comb begin
        next_count = count;
        if (BUS_IN.wr_low) begin
            next_count = CFG_IN.atomic_wide_access
                ? {shadow, BUS_IN.wdata}
                : {count[HIGH_LSB +: BYTE_W], BUS_IN.wdata};
        end else if (BUS_IN.wr_high && !CFG_IN.atomic_wide_access) begin
            next_count = {BUS_IN.wdata, count[LOW_LSB +: BYTE_W]};
        end else if (SPECIAL_EVENT_IN) begin
            next_count = CNT_RST;
        end else if (inc) begin
            next_count = count + CNT_ONE;
        end
    end

    always_comb begin
        next_shadow = shadow;
        if (CFG_IN.atomic_wide_access && BUS_IN.wr_high) begin
            next_shadow = BUS_IN.wdata;
        end else if (CFG_IN.atomic_wide_access && BUS_IN.rd_low) begin
            next_shadow = count[HIGH_LSB +: BYTE_W];
        end
    end

    // Reads come from the registered count, or in atomic mode a high read from the shadow, so each byte is whole
    always_comb begin
        next_rdata = RDATA_OUT;
        if (BUS_IN.rd_low) begin
            next_rdata = count[LOW_LSB +: BYTE_W];
        end else if (BUS_IN.rd_high) begin
            next_rdata = CFG_IN.atomic_wide_access ? shadow
                       : count[HIGH_LSB +: BYTE_W];
        end
    end

    assign next_ps_cnt = ps_clr ? PS_RST
                       : ps_tick ? ps_cnt + PS_ONE : ps_cnt;

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            count     <= CNT_RST;
            shadow    <= BYTE_RST;
            RDATA_OUT <= BYTE_RST;
            ps_cnt    <= PS_RST;
            phase     <= PHASE_RST;
        end else begin
            count     <= next_count;
            shadow    <= next_shadow;
            RDATA_OUT <= next_rdata;
            ps_cnt    <= next_ps_cnt;
            phase     <= phase + 2'h1;
        end
    end

    // External edge tracking
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ext_sel_d <= 1'b0;
            need_fall <= 1'b1;
            ext_pend  <= 1'b0;
        end else begin
            ext_sel_d <= ext_sel;
            if (any_wr || !CFG_IN.on) begin
                need_fall <= 1'b1;
            end else if (ext_fall) begin
                need_fall <= 1'b0;
            end
            if (!ext_is || CFG_IN.input_unaligned || any_wr || instr_tick) begin
                ext_pend <= 1'b0;
            end else if (ext_edge) begin
                ext_pend <= 1'b1;
            end
        end
    end

    // Sticky flags: a set beats a same-cycle clear
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            gate_lvl <= 1'b0;
            ovf_flag <= 1'b0;
            gev_flag <= 1'b0;
        end else begin
            gate_lvl <= gate_ctl;
            ovf_flag <= ovf_set | (ovf_flag & ~OVERFLOW_FLAG_CLR_IN);
            gev_flag <= gate_fall |
                        (gev_flag & ~GATE_EVENT_FLAG_CLR_IN);
        end
    end

    assign COUNT_VALUE_OUT       = count;
    assign OVERFLOW_FLAG_OUT     = ovf_flag;
    assign GATE_EVENT_FLAG_OUT   = gev_flag;
    assign GATE_LEVEL_STATUS_OUT = gate_lvl;
    assign PULSE_ARM_DONE_OUT    = arm_done;
    assign OVERFLOW_IRQ_OUT      = ovf_flag & CFG_IN.overflow_irq_enable;
    assign GATE_IRQ_OUT          = gev_flag & CFG_IN.gate_event_irq_enable;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    property p_off_hold;
        !CFG_IN.on && !any_wr && !SPECIAL_EVENT_IN |=> $stable(count);
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("count moved while timer off");

    property p_gate_hold;
        CFG_IN.gate_qualify_enable && !gate_ctl && !any_wr &&
            !SPECIAL_EVENT_IN |=> $stable(count);
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("count moved with gate inactive");

    property p_full_rate;
        CFG_IN.on && !CFG_IN.gate_qualify_enable &&
            CFG_IN.clk_src == SRC_FULL && CFG_IN.prescale_select == 2'h0 &&
            !SLEEP_IN && !any_wr && !SPECIAL_EVENT_IN
            |=> count == $past(count) + CNT_ONE;
    endproperty
    a_full_rate: assert property (p_full_rate)
        else $error("full-rate source did not step every clock");

    property p_need_fall;
        need_fall && ext_is && !ext_pend && !any_wr &&
            !SPECIAL_EVENT_IN |=> $stable(count);
    endproperty
    a_need_fall: assert property (p_need_fall)
        else $error("rising edge counted before falling edge");

    property p_fall_rearm;
        any_wr || !CFG_IN.on |=> need_fall;
    endproperty
    a_fall_rearm: assert property (p_fall_rearm)
        else $error("write or disable did not re-arm falling edge");

    property p_low_load;
        BUS_IN.wr_low && CFG_IN.atomic_wide_access
            |=> count == {$past(shadow), $past(BUS_IN.wdata)};
    endproperty
    a_low_load: assert property (p_low_load)
        else $error("atomic low write did not load whole count");

    property p_ps_clear;
        BUS_IN.wr_low |=> ps_cnt == PS_RST;
    endproperty
    a_ps_clear: assert property (p_ps_clear)
        else $error("prescaler not cleared by low write");

    property p_ps_keep;
        BUS_IN.wr_high && !BUS_IN.wr_low && CFG_IN.atomic_wide_access &&
            !ps_tick |=> $stable(ps_cnt);
    endproperty
    a_ps_keep: assert property (p_ps_keep)
        else $error("atomic high write disturbed prescaler");

    property p_shadow_read;
        BUS_IN.rd_low && !BUS_IN.wr_high && CFG_IN.atomic_wide_access
            ##1 BUS_IN.rd_high && !BUS_IN.rd_low && !BUS_IN.wr_high &&
                CFG_IN.atomic_wide_access
            |=> RDATA_OUT == $past(count[HIGH_LSB +: BYTE_W], 2);
    endproperty
    a_shadow_read: assert property (p_shadow_read)
        else $error("high read did not return snapshot");

    property p_overflow;
        ovf_set |=> OVERFLOW_FLAG_OUT && count == CNT_RST;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("wrap did not set overflow flag");

    property p_special;
        SPECIAL_EVENT_IN && !cnt_wr && !OVERFLOW_FLAG_CLR_IN
            |=> count == CNT_RST && OVERFLOW_FLAG_OUT == $past(ovf_flag);
    endproperty
    a_special: assert property (p_special)
        else $error("special event mishandled");

    property p_gate_event;
        gate_fall |=> GATE_EVENT_FLAG_OUT && !GATE_LEVEL_STATUS_OUT;
    endproperty
    a_gate_event: assert property (p_gate_event)
        else $error("gate fall did not set event flag");

    property p_asleep;
        SLEEP_IN && !(ext_is && CFG_IN.input_unaligned) && !any_wr &&
            !SPECIAL_EVENT_IN |=> $stable(count);
    endproperty
    a_asleep: assert property (p_asleep)
        else $error("aligned count advanced during sleep");

    c_overflow: cover property (ovf_set);
    c_gate_event: cover property (gate_fall && CFG_IN.gate_single_pulse_mode);
    c_ext_count: cover property (ext_tick && inc && CFG_IN.input_unaligned);
    c_shadow_read: cover property (BUS_IN.rd_high &&
                                   CFG_IN.atomic_wide_access);
endmodule
`default_nettype wire

// file: tb/gtc_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module gtc_pins_model (
    // Clock
    input  wire logic MCLK_IN,
    // Count and gate pins
    output logic      EXT_OUT,
    output logic [3:0] GATE_OUT
);
    initial begin
        EXT_OUT = 1'b0;
        GATE_OUT = 4'h0;
    end
    // Each pulse ends low, so every later rise follows a fall
    task automatic pulse_ext(input int n);
        repeat (n) begin
            EXT_OUT = 1'b1;
            repeat (8) @(negedge MCLK_IN);
            EXT_OUT = 1'b0;
            repeat (8) @(negedge MCLK_IN);
        end
    endtask
    task automatic set_gate(input int idx, input logic v);
        GATE_OUT[idx] = v;
    endtask
endmodule
`default_nettype wire

// file: tb/gated_16bit_timer_counter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gated_16bit_timer_counter_tb_top;
    import gtc_pkg::*;
    logic        MCLK_IN = 1'b0;
    logic        RST_IN = 1'b1;
    gtc_cfg_t    cfg = '0;
    gtc_bus_t    bus = '0;
    logic        arm = 1'b0;
    logic        ovf_clr = 1'b0;
    logic        gev_clr = 1'b0;
    logic        spec = 1'b0;
    logic        sleep = 1'b0;
    logic        ext;
    logic [3:0]  gate;
    logic [7:0]  rdata;
    logic [15:0] cnt;
    logic        ovf, gev, gst, armd, ovf_irq, g_irq;
    int          fails = 0;
    int          compares = 0;

    always #2.5 MCLK_IN = ~MCLK_IN;

    gtc_pins_model pins (.MCLK_IN(MCLK_IN), .EXT_OUT(ext), .GATE_OUT(gate));

    gtc_timer dut (
        .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .CFG_IN(cfg), .BUS_IN(bus),
        .RDATA_OUT(rdata), .PULSE_ARM_SET_IN(arm),
        .OVERFLOW_FLAG_CLR_IN(ovf_clr), .GATE_EVENT_FLAG_CLR_IN(gev_clr),
        .SPECIAL_EVENT_IN(spec), .SLEEP_IN(sleep),
        .EXTERNAL_COUNT_INPUT_IN(ext), .GATE_INPUT_IN(gate),
        .COUNT_VALUE_OUT(cnt), .OVERFLOW_FLAG_OUT(ovf),
        .GATE_EVENT_FLAG_OUT(gev), .GATE_LEVEL_STATUS_OUT(gst),
        .PULSE_ARM_DONE_OUT(armd), .OVERFLOW_IRQ_OUT(ovf_irq),
        .GATE_IRQ_OUT(g_irq)
    );

    task automatic results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge MCLK_IN);
    endtask
    task automatic wr(input logic hi, input logic [7:0] d);
        bus.wdata = d;
        bus.wr_high = hi;
        bus.wr_low = !hi;
        cyc(1);
        bus.wr_high = 1'b0;
        bus.wr_low = 1'b0;
    endtask
    task automatic rd(input logic hi, input logic [7:0] exp);
        bus.rd_high = hi;
        bus.rd_low = !hi;
        cyc(1);
        bus.rd_high = 1'b0;
        bus.rd_low = 1'b0;
        chk({8'h00, rdata}, {8'h00, exp});
    endtask
    // Count for n clocks, then stop
    task automatic run(input int n);
        cfg.on = 1'b1;
        cyc(n);
        cfg.on = 1'b0;
        cyc(1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    // Bounded wait for the gate level status
    task automatic wait_st(input logic v);
        for (int i = 0; i < 40 && gst !== v; i++) cyc(1);
        compares++;
        if (gst !== v) begin
            fails++;
            $display("wrong value at %0t: gate status wait ran out", $time);
            results();
        end
    endtask

    initial begin
        cyc(20);
        RST_IN = 1'b0;
        cyc(1);
        chk(cnt, 16'h0000);
        cfg.clk_src = SRC_FULL;
        wr(1'b1, 8'h12);
        wr(1'b0, 8'h34);
        chk(cnt, 16'h1234);
        rd(1'b1, 8'h12);
        for (int p = 0; p < 4; p++) begin
            cfg.prescale_select = 2'(p);
            wr(1'b0, 8'h00);
            run(64);
            chk(cnt, 16'h1200 + 16'(64 >> p));
        end
        // Atomic access; high write must keep the prescaler
        wr(1'b0, 8'h00);
        run(4);
        cfg.atomic_wide_access = 1'b1;
        wr(1'b1, 8'h56);
        chk(cnt, 16'h1200);
        run(4);
        chk(cnt, 16'h1201);
        wr(1'b0, 8'hcd);
        chk(cnt, 16'h56cd);
        rd(1'b0, 8'hcd);
        cfg.atomic_wide_access = 1'b0;
        wr(1'b1, 8'h99);
        cfg.atomic_wide_access = 1'b1;
        rd(1'b1, 8'h56);
        rd(1'b0, 8'hcd);
        rd(1'b1, 8'h99);
        cfg.atomic_wide_access = 1'b0;
        cfg.prescale_select = 2'h0;
        // Wrap to zero
        wr(1'b1, 8'hff);
        wr(1'b0, 8'hff);
        cfg.overflow_irq_enable = 1'b1;
        run(1);
        chk(cnt, 16'h0000);
        chk({14'h0, ovf, ovf_irq}, 16'h0003);
        pulse(ovf_clr);
        cyc(1);
        chk({15'h0, ovf}, 16'h0000);
        // Special event, alone and against a write
        wr(1'b0, 8'h55);
        pulse(spec);
        cyc(1);
        chk({ovf, cnt[14:0]}, 16'h0000);
        spec = 1'b1;
        wr(1'b0, 8'h77);
        spec = 1'b0;
        cyc(1);
        chk(cnt, 16'h0077);
        // Gate qualification, source 2 selected, source 1 high
        pins.set_gate(1, 1'b1);
        cfg.gate_qualify_enable = 1'b1;
        cfg.gate_polarity = 1'b1;
        cfg.gate_source_select = 2'h2;
        wr(1'b0, 8'h00);
        run(20);
        chk(cnt, 16'h0000);
        cfg.gate_polarity = 1'b0;
        wait_st(1'b1);
        run(20);
        chk(cnt, 16'h0014);
        // Gate event with qualification off
        cfg.gate_qualify_enable = 1'b0;
        cfg.gate_event_irq_enable = 1'b1;
        pulse(gev_clr);
        pins.set_gate(2, 1'b1);
        wait_st(1'b0);
        cyc(2);
        chk({14'h0, gev, g_irq}, 16'h0003);
        // Polarity first, toggle enable in a later step
        cfg.gate_polarity = 1'b1;
        cyc(2);
        cfg.gate_toggle_mode = 1'b1;
        wait_st(1'b0);
        for (int t = 0; t < 2; t++) begin
            pins.set_gate(2, 1'b0);
            cyc(8);
            pins.set_gate(2, 1'b1);
            wait_st(t == 0);
            cyc(4);
        end
        cfg.gate_toggle_mode = 1'b0;
        wait_st(1'b1);
        // Single pulse window
        pins.set_gate(2, 1'b0);
        wait_st(1'b0);
        cfg.gate_qualify_enable = 1'b1;
        cfg.gate_single_pulse_mode = 1'b1;
        pulse(gev_clr);
        pulse(arm);
        cyc(1);
        chk({15'h0, armd}, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            wr(1'b0, 8'h00);
            cfg.on = 1'b1;
            pins.set_gate(2, 1'b1);
            cyc(20);
            pins.set_gate(2, 1'b0);
            cyc(10);
            cfg.on = 1'b0;
            cyc(1);
            chk({14'h0, armd, gev}, 16'h0001);
            chk(cnt, (k == 0) ? 16'h0014 : 16'h0000);
        end
        chk(cnt, 16'h0000);
        pulse(arm);
        cyc(1);
        cfg.gate_single_pulse_mode = 1'b0;
        cyc(2);
        chk({15'h0, armd}, 16'h0000);
        // External pin counting, awake then asleep
        cfg.gate_qualify_enable = 1'b0;
        cfg.clk_src = SRC_EXT;
        wr(1'b0, 8'h00);
        cfg.on = 1'b1;
        pins.pulse_ext(3);
        chk(cnt, 16'h0002);
        cfg.input_unaligned = 1'b1;
        sleep = 1'b1;
        pins.pulse_ext(2);
        chk(cnt, 16'h0004);
        cfg.input_unaligned = 1'b0;
        pins.pulse_ext(2);
        chk(cnt, 16'h0004);
        cfg.on = 1'b0;
        sleep = 1'b0;
        // Instruction-rate source: one count per four clocks
        cfg.clk_src = SRC_INSTR;
        wr(1'b0, 8'h00);
        run(64);
        chk(cnt, 16'h0010);
        // Inverted pin: pin rise arms, pin fall counts
        cfg.clk_src = SRC_EXT_INV;
        wr(1'b0, 8'h00);
        cfg.on = 1'b1;
        pins.pulse_ext(2);
        chk(cnt, 16'h0002);
        cfg.on = 1'b0;
        results();
    end
endmodule
`default_nettype wire
